// ### hdl/nipc_arbiter.sv
// pending request arbiter: software level first, fixed vector order second
`timescale 1ns/1ps
`default_nettype none
module nipc_arbiter #(
	parameter int NUM_VEC = nipc_pkg::NUM_VEC,
	parameter int IDX_W   = 4
) (
	input  wire logic [NUM_VEC-1:0]   req_vec,
	input  wire logic [2*NUM_VEC-1:0] prio_vec,
	input  wire logic [1:0]           cur_level,
	output logic                      win_valid,
	output logic [IDX_W-1:0]          win_idx,
	output logic [1:0]                win_level
);
	logic [1:0] best_rank;
	logic [1:0] cand_rank;

	// scan from lowest fixed priority upward so that ties go to the lower index
	always_comb begin
		win_valid = 1'b0;
		win_idx   = '0;
		win_level = nipc_pkg::LVL_MAIN;
		best_rank = 2'h0;
		cand_rank = 2'h0;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			cand_rank = nipc_pkg::prio_rank(prio_vec[2*i +: 2]);
			if (req_vec[i] && (cand_rank > nipc_pkg::prio_rank(cur_level))) begin
				if (!win_valid || (cand_rank >= best_rank)) begin
					win_valid = 1'b1;
					win_idx   = IDX_W'(i);
					win_level = prio_vec[2*i +: 2];
					best_rank = cand_rank;
				end
			end
		end
	end
endmodule // nipc_arbiter
`default_nettype wire

// ### hdl/nipc_ctrl.sv
// nested interrupt priority controller: arbitration, context stacking, return and reset fetch
// Summary of operation
// - fourteen maskable vectors plus reset, trap; four levels
// - reset and trap are never masked
// - vectors fill FFE0h..FFFFh in hardware priority order
// - current level sits in condition code bits 5,3
// - requests taken only at instruction end
// - entry pushes PC, X, A, CC
// - entry loads current level from vector field
// - then PC loads from vector, handler fetch
// - return pops saved context from stack
// - return restores current level from popped CC
// - level codes: 10,01,00,11; 11 masks all
// - highest software level wins first
// - equal levels: highest hardware priority wins
// - unserved requests stay latched as pending
// - fixed order is unique, always one winner
// - reset and trap outrank every maskable source
// - reset vector read from FFFEh-FFFFh
// - reset vector fetch takes four cycles, two of them reads
// - served only if enabled and above level
// - reset/trap set level 3; reset skips stacking
// - writing level 0 code keeps old field
`timescale 1ns/1ps
`default_nettype none
module nipc_ctrl #(
	parameter int NUM_VEC = nipc_pkg::NUM_VEC
) (
	input  wire logic               SYS_CLK,
	input  wire logic               RSTN,
	input  wire logic [4:0]         AVS_ADDRESS,
	input  wire logic               AVS_READ,
	input  wire logic               AVS_WRITE,
	input  wire logic [31:0]        AVS_WRITEDATA,
	input  wire logic [3:0]         AVS_BYTEENABLE,
	output logic                    AVS_WAITREQUEST,
	output logic [31:0]             AVS_READDATA,
	input  wire logic               INSTR_DONE,
	input  wire logic               TRAP_EXEC,
	input  wire logic               RETURN_FROM_INTERRUPT_EXEC,
	input  wire logic [NUM_VEC-1:0] IRQ_REQ,
	input  wire logic [NUM_VEC-1:0] IRQ_CLR,
	input  wire logic [15:0]        CPU_PC,
	input  wire logic [7:0]         CPU_X,
	input  wire logic [7:0]         CPU_A,
	input  wire logic [7:0]         CPU_CC,
	input  wire logic [7:0]         MEM_RDATA,
	output logic [15:0]             MEM_ADDR,
	output logic                    MEM_RE,
	output logic                    MEM_WE,
	output logic [7:0]              MEM_WDATA,
	output logic                    CORE_HOLD,
	output logic                    PC_LOAD,
	output logic [15:0]             PC_VALUE,
	output logic                    CTX_LOAD,
	output logic [7:0]              CTX_X,
	output logic [7:0]              CTX_A,
	output logic [7:0]              CTX_CC,
	output logic [7:0]              STACK_PTR_LOW,
	output logic                    CUR_PRIO_HIGH_BIT,
	output logic                    CUR_PRIO_LOW_BIT
);
	localparam int IDX_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// declarations
	nipc_pkg::nipc_state_type state_q;
	logic [2:0]           cnt_q;
	logic [7:0]           sp_q;
	logic [15:0]          serv_vec_q;
	logic [1:0]           new_lvl_q;
	logic [1:0]           cur_prio_q;
	logic [7:0]           pc_hi_q;
	logic [7:0]           ctx_q [5];
	logic [7:0]           pop_q [4];
	logic [2*NUM_VEC-1:0] prio_q;
	logic [NUM_VEC-1:0]   enable_q;
	logic [NUM_VEC-1:0]   pend_q;
	logic                 trap_pend_q;
	logic                 waitreq_q;
	logic [31:0]          rdata_q;
	logic                 hold_q;
	logic [15:0]          mem_addr_q;
	logic                 mem_re_q;
	logic                 mem_we_q;
	logic [7:0]           mem_wdata_q;
	logic                 pc_load_q;
	logic [15:0]          pc_value_q;
	logic                 ctx_load_q;
	logic [7:0]           ctx_x_q;
	logic [7:0]           ctx_a_q;
	logic [7:0]           ctx_cc_q;

	logic                 win_valid;
	logic [IDX_W-1:0]     win_idx;
	logic [1:0]           win_level;
	logic                 boundary;
	logic                 trap_now;
	logic                 take_return_from_interrupt;
	logic                 take_trap;
	logic                 take_irq;
	logic [NUM_VEC-1:0]   take_onehot;
	logic                 push_end;
	logic                 pop_end;
	logic                 bus_take;
	logic                 wr_fire;
	logic [7:0]           cc_snap;
	logic [31:0]          prio_view;
	logic [31:0]          rd_word;

	// exact byte address match
	function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] offset);
		reg_hit = (addr == offset);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// arbitration on latched flags only
	nipc_arbiter #(
		.NUM_VEC (NUM_VEC),
		.IDX_W   (IDX_W)
	) u_arbiter (
		.req_vec   (pend_q & enable_q),
		.prio_vec  (prio_q),
		.cur_level (cur_prio_q),
		.win_valid (win_valid),
		.win_idx   (win_idx),
		.win_level (win_level)
	);

	// acceptance decode; return beats a new request at the same boundary
	assign boundary    = INSTR_DONE && (state_q == nipc_pkg::ST_IDLE);
	assign trap_now    = TRAP_EXEC || trap_pend_q;
	assign take_return_from_interrupt   = boundary && RETURN_FROM_INTERRUPT_EXEC;
	assign take_trap   = boundary && !RETURN_FROM_INTERRUPT_EXEC && trap_now;
	assign take_irq    = boundary && !RETURN_FROM_INTERRUPT_EXEC && !trap_now && win_valid;
	assign take_onehot = take_irq ? (NUM_VEC'(1) << win_idx) : '0;
	assign push_end    = (state_q == nipc_pkg::ST_PUSH) && (cnt_q == nipc_pkg::CTX_LAST);
	assign pop_end     = (state_q == nipc_pkg::ST_POP) && (cnt_q == nipc_pkg::POP_LAST);

	// stacked CC carries the live level bits
	always_comb begin
		cc_snap = CPU_CC;
		cc_snap[nipc_pkg::PRIO_HI_BIT] = cur_prio_q[1];
		cc_snap[nipc_pkg::PRIO_LO_BIT] = cur_prio_q[0];
	end

	////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then a single ready cycle
	assign bus_take = (AVS_READ || AVS_WRITE) && waitreq_q;
	assign wr_fire  = AVS_WRITE && !waitreq_q;

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			waitreq_q <= 1'b1;
		end else begin
			waitreq_q <= !bus_take;
		end
	end

	// unused fields of the last priority word read as ones
	always_comb begin
		prio_view = '1;
		for (int i = 0; i < NUM_VEC; i++) begin
			prio_view[2*i +: 2] = prio_q[2*i +: 2];
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_word = 32'h0;
		for (int k = 0; k < 4; k++) begin
			if (reg_hit(AVS_ADDRESS, nipc_pkg::REG_PRIO0 + 5'(4 * k))) begin
				rd_word = {24'h0, prio_view[8*k +: 8]};
			end
		end
		if (reg_hit(AVS_ADDRESS, nipc_pkg::REG_ENABLE)) begin
			rd_word = 32'(enable_q);
		end
		if (reg_hit(AVS_ADDRESS, nipc_pkg::REG_PENDING)) begin
			rd_word = 32'(pend_q);
		end
		if (reg_hit(AVS_ADDRESS, nipc_pkg::REG_STATUS)) begin
			rd_word = {28'h0, trap_pend_q, state_q, hold_q};
		end
		if (reg_hit(AVS_ADDRESS, nipc_pkg::REG_LEVEL)) begin
			rd_word = {30'h0, cur_prio_q};
		end
	end

	// read data captured in the wait cycle, stands while ready is shown
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			rdata_q <= 32'h0;
		end else if (bus_take && AVS_READ) begin
			rdata_q <= rd_word;
		end
	end

	// vector level fields and enables
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			prio_q   <= '1; // every field resets to the level 3 code
			enable_q <= '0;
		end else if (wr_fire) begin
			for (int i = 0; i < NUM_VEC; i++) begin
				if (reg_hit(AVS_ADDRESS, nipc_pkg::REG_PRIO0 + 5'(4 * (i / 4)))
					&& AVS_BYTEENABLE[0]) begin
					prio_q[2*i +: 2] <= nipc_pkg::keep_level(prio_q[2*i +: 2],
						AVS_WRITEDATA[2*(i%4) +: 2]);
				end
				if (reg_hit(AVS_ADDRESS, nipc_pkg::REG_ENABLE) && AVS_BYTEENABLE[i/8]) begin
					enable_q[i] <= AVS_WRITEDATA[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pending latches: a new request wins over any clear in the same cycle
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			pend_q      <= '0;
			trap_pend_q <= 1'b0;
		end else begin
			pend_q      <= IRQ_REQ | (pend_q & ~(IRQ_CLR | take_onehot));
			// a trap served at its own boundary is consumed, not left latched
			trap_pend_q <= !take_trap && (TRAP_EXEC || trap_pend_q);
		end
	end

	// current level: reset leaves it at 3, entry and return reload it
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			cur_prio_q <= nipc_pkg::LVL_DIS;
		end else if (push_end) begin
			cur_prio_q <= new_lvl_q;
		end else if (pop_end) begin
			cur_prio_q <= {pop_q[0][nipc_pkg::PRIO_HI_BIT], pop_q[0][nipc_pkg::PRIO_LO_BIT]};
		end else if (wr_fire && reg_hit(AVS_ADDRESS, nipc_pkg::REG_LEVEL)
			&& AVS_BYTEENABLE[0] && (state_q == nipc_pkg::ST_IDLE)) begin
			cur_prio_q <= AVS_WRITEDATA[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer: push context, fetch vector, pop context
	// memory reads return data one cycle after the read is presented
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			state_q     <= nipc_pkg::ST_FETCH; // reset fetches without stacking
			cnt_q       <= 3'h0;
			sp_q        <= nipc_pkg::SP_RESET;
			serv_vec_q  <= nipc_pkg::RESET_VEC;
			new_lvl_q   <= nipc_pkg::LVL_DIS;
			hold_q      <= 1'b1;
			mem_addr_q  <= 16'h0;
			mem_re_q    <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_wdata_q <= 8'h0;
			pc_load_q   <= 1'b0;
			pc_value_q  <= 16'h0;
			pc_hi_q     <= 8'h0;
			ctx_load_q  <= 1'b0;
			ctx_x_q     <= 8'h0;
			ctx_a_q     <= 8'h0;
			ctx_cc_q    <= 8'h0;
		end else begin
			mem_re_q   <= 1'b0;
			mem_we_q   <= 1'b0;
			pc_load_q  <= 1'b0;
			ctx_load_q <= 1'b0;
			unique case (state_q)
				nipc_pkg::ST_IDLE: begin
					cnt_q <= 3'h0;
					if (take_return_from_interrupt) begin
						state_q <= nipc_pkg::ST_POP;
						hold_q  <= 1'b1;
					end else if (take_trap || take_irq) begin
						state_q    <= nipc_pkg::ST_PUSH;
						hold_q     <= 1'b1;
						serv_vec_q <= take_trap ? nipc_pkg::TRAP_VEC
							: nipc_pkg::VEC_FIRST - 16'({win_idx, 1'b0});
						new_lvl_q  <= take_trap ? nipc_pkg::LVL_DIS : win_level;
						ctx_q[0]   <= CPU_PC[7:0];
						ctx_q[1]   <= CPU_PC[15:8];
						ctx_q[2]   <= CPU_X;
						ctx_q[3]   <= CPU_A;
						ctx_q[4]   <= cc_snap;
					end
				end
				nipc_pkg::ST_PUSH: begin
					// low PC byte goes first, at the highest address
					mem_we_q    <= 1'b1;
					mem_addr_q  <= {nipc_pkg::STACK_PAGE, sp_q};
					mem_wdata_q <= ctx_q[cnt_q];
					sp_q        <= sp_q - 8'h1;
					if (cnt_q == nipc_pkg::CTX_LAST) begin
						state_q <= nipc_pkg::ST_FETCH;
						cnt_q   <= 3'h0;
					end else begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
				nipc_pkg::ST_FETCH: begin
					if (cnt_q < nipc_pkg::FETCH_CYCLES) begin
						mem_re_q   <= 1'b1;
						mem_addr_q <= serv_vec_q | {15'h0, cnt_q[0]};
					end
					if (cnt_q == nipc_pkg::FETCH_HI_CAP) begin
						pc_hi_q <= MEM_RDATA;
					end
					if (cnt_q == nipc_pkg::FETCH_LAST) begin
						pc_load_q  <= 1'b1;
						pc_value_q <= {pc_hi_q, MEM_RDATA};
						hold_q     <= 1'b0;
						state_q    <= nipc_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
				nipc_pkg::ST_POP: begin
					// pops CC, A, X, PCH, PCL in that order
					if (cnt_q <= nipc_pkg::CTX_LAST) begin
						mem_re_q   <= 1'b1;
						mem_addr_q <= {nipc_pkg::STACK_PAGE, sp_q + 8'h1};
						sp_q       <= sp_q + 8'h1;
					end
					if ((cnt_q >= nipc_pkg::POP_FIRST_CAP) && (cnt_q < nipc_pkg::POP_LAST)) begin
						pop_q[2'(cnt_q - nipc_pkg::POP_FIRST_CAP)] <= MEM_RDATA;
					end
					if (cnt_q == nipc_pkg::POP_LAST) begin
						ctx_load_q <= 1'b1;
						ctx_cc_q   <= pop_q[0];
						ctx_a_q    <= pop_q[1];
						ctx_x_q    <= pop_q[2];
						pc_load_q  <= 1'b1;
						pc_value_q <= {pop_q[3], MEM_RDATA};
						hold_q     <= 1'b0;
						state_q    <= nipc_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
			endcase
		end
	end

	// outputs straight from flops
	assign AVS_WAITREQUEST   = waitreq_q;
	assign AVS_READDATA      = rdata_q;
	assign MEM_ADDR          = mem_addr_q;
	assign MEM_RE            = mem_re_q;
	assign MEM_WE            = mem_we_q;
	assign MEM_WDATA         = mem_wdata_q;
	assign CORE_HOLD         = hold_q;
	assign PC_LOAD           = pc_load_q;
	assign PC_VALUE          = pc_value_q;
	assign CTX_LOAD          = ctx_load_q;
	assign CTX_X             = ctx_x_q;
	assign CTX_A             = ctx_a_q;
	assign CTX_CC            = ctx_cc_q;
	assign STACK_PTR_LOW     = sp_q;
	assign CUR_PRIO_HIGH_BIT = cur_prio_q[1];
	assign CUR_PRIO_LOW_BIT  = cur_prio_q[0];

	////////////////////////////////////////////////////////////////////////////
	// checks: helper flags whether any eligible request beats the winner
	logic better_exists;
	always_comb begin
		better_exists = 1'b0;
		for (int j = 0; j < NUM_VEC; j++) begin
			if (pend_q[j] && enable_q[j] && (nipc_pkg::prio_rank(prio_q[2*j +: 2])
				> nipc_pkg::prio_rank(win_level))) begin
				better_exists = 1'b1;
			end
			if (pend_q[j] && enable_q[j] && (IDX_W'(j) < win_idx)
				&& (prio_q[2*j +: 2] == win_level)) begin
				better_exists = 1'b1;
			end
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	AST_BUS_ONE_WAIT: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request not answered after one wait cycle");
	AST_RESET_FETCH: assert property ($rose(RSTN) |=> MEM_RE && (MEM_ADDR == nipc_pkg::RESET_VEC) ##1 MEM_RE && (MEM_ADDR == (nipc_pkg::RESET_VEC | 16'h1)) ##1 !MEM_RE ##1 PC_LOAD)
		else $error("reset vector fetch wrong");
	AST_RESET_NO_STACK: assert property ($rose(RSTN) |-> !MEM_WE [*4] ##0 (cur_prio_q == nipc_pkg::LVL_DIS))
		else $error("reset stacked context or left level 3");
	AST_PUSH_FIVE: assert property ((take_trap || take_irq) |=> !MEM_WE ##1 MEM_WE [*5] ##1 !MEM_WE)
		else $error("context push is not five bytes");
	AST_ENTRY_LEVEL: assert property (push_end |=> cur_prio_q == $past(new_lvl_q))
		else $error("entry level not loaded");
	AST_VECTOR_READ: assert property (push_end |=> ##1 MEM_RE && (MEM_ADDR == serv_vec_q))
		else $error("vector not fetched after push");
	AST_RETURN_LEVEL: assert property (CTX_LOAD |-> PC_LOAD && ({CUR_PRIO_HIGH_BIT, CUR_PRIO_LOW_BIT} == {CTX_CC[nipc_pkg::PRIO_HI_BIT], CTX_CC[nipc_pkg::PRIO_LO_BIT]}))
		else $error("return did not restore level");
	AST_ABOVE_LEVEL: assert property (take_irq |-> (nipc_pkg::prio_rank(win_level) > nipc_pkg::prio_rank(cur_prio_q)) && !better_exists)
		else $error("served request was not the best eligible one");
	AST_PEND_HELD: assert property (##1 ((pend_q & $past(pend_q & ~(IRQ_CLR | take_onehot))) == $past(pend_q & ~(IRQ_CLR | take_onehot))))
		else $error("pending request lost");
	AST_TRAP_FIRST: assert property (boundary && trap_now && !RETURN_FROM_INTERRUPT_EXEC |=> serv_vec_q == nipc_pkg::TRAP_VEC)
		else $error("trap did not win arbitration");
	AST_BOUNDARY_ONLY: assert property ((state_q == nipc_pkg::ST_IDLE) && !INSTR_DONE |=> state_q == nipc_pkg::ST_IDLE)
		else $error("service began mid instruction");
	AST_LEVEL0_KEPT: assert property (wr_fire && reg_hit(AVS_ADDRESS, nipc_pkg::REG_PRIO0) && AVS_BYTEENABLE[0] && (AVS_WRITEDATA[1:0] == nipc_pkg::LVL_MAIN) |=> prio_q[1:0] == $past(prio_q[1:0]))
		else $error("level 0 code was stored");

	COV_IRQ_ENTRY: cover property (take_irq ##[1:20] PC_LOAD);
	COV_TRAP_ENTRY: cover property (take_trap ##[1:20] PC_LOAD);
	COV_NESTED: cover property (take_irq && (cur_prio_q != nipc_pkg::LVL_MAIN));
	COV_RETURN: cover property (pop_end);
endmodule // nipc_ctrl
`default_nettype wire

// ### hdl/nipc_pkg.sv
// constants, state type and shared functions of the nested interrupt priority controller
`default_nettype none
package nipc_pkg;
	// vector map, top of memory
	localparam int          NUM_VEC     = 14;
	localparam logic [15:0] VEC_FIRST   = 16'hFFFA;
	localparam logic [15:0] TRAP_VEC    = 16'hFFFC;
	localparam logic [15:0] RESET_VEC   = 16'hFFFE;
	localparam logic [15:0] VEC_LOWEST  = 16'hFFE0;
	// stack page and pointer
	localparam logic [7:0]  STACK_PAGE  = 8'h01;
	localparam logic [7:0]  SP_RESET    = 8'hFF;
	// sequence counts
	localparam logic [2:0]  CTX_LAST      = 3'h4;
	localparam logic [2:0]  FETCH_CYCLES  = 3'h2;
	localparam logic [2:0]  FETCH_HI_CAP  = 3'h2;
	localparam logic [2:0]  FETCH_LAST    = 3'h3;
	localparam logic [2:0]  POP_FIRST_CAP = 3'h2;
	localparam logic [2:0]  POP_LAST      = 3'h6;
	// priority bit positions in the condition code register
	localparam int          PRIO_HI_BIT = 5;
	localparam int          PRIO_LO_BIT = 3;
	// level codes {high bit, low bit}
	localparam logic [1:0]  LVL_MAIN = 2'h2;
	localparam logic [1:0]  LVL_ONE  = 2'h1;
	localparam logic [1:0]  LVL_TWO  = 2'h0;
	localparam logic [1:0]  LVL_DIS  = 2'h3;
	// register byte offsets
	localparam logic [4:0]  REG_PRIO0   = 5'h00;
	localparam logic [4:0]  REG_ENABLE  = 5'h10;
	localparam logic [4:0]  REG_PENDING = 5'h14;
	localparam logic [4:0]  REG_STATUS  = 5'h18;
	localparam logic [4:0]  REG_LEVEL   = 5'h1C;
	localparam logic [7:0]  PRIO_RESET  = 8'hFF;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_PUSH  = 2'h1,
		ST_FETCH = 2'h3,
		ST_POP   = 2'h2
	} nipc_state_type;

	// level code to rank 0..3
	function automatic logic [1:0] prio_rank(input logic [1:0] code);
		unique case (code)
			LVL_MAIN: prio_rank = 2'h0;
			LVL_ONE:  prio_rank = 2'h1;
			LVL_TWO:  prio_rank = 2'h2;
			LVL_DIS:  prio_rank = 2'h3;
		endcase
	endfunction

	// the main level code can never be stored in a vector field
	function automatic logic [1:0] keep_level(input logic [1:0] old_code, input logic [1:0] new_code);
		keep_level = (new_code == LVL_MAIN) ? old_code : new_code;
	endfunction
endpackage
`default_nettype wire

// ### verif/nested_interrupt_priority_controller_bench.sv
// self-checking bench: register bus, core boundaries and stack traffic
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_priority_controller_bench;
	logic        sys_clk, rstn, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0]  avs_byteenable;
	logic        instr_done, trap_exec, return_from_interrupt_exec, mem_re, mem_we;
	logic [13:0] irq_req, irq_clr;
	logic [15:0] cpu_pc, mem_addr, pc_value;
	logic [7:0]  cpu_x, cpu_a, cpu_cc, mem_rdata, mem_wdata, ctx_x, ctx_a, ctx_cc, sp_low;
	logic        core_hold, pc_load, ctx_load, prio_hi, prio_lo, ctx_seen;
	int          errors, n_compared, re_n, we_n, p;

	////////////////////////////////////////////////////////////////////////////////
	nipc_ctrl uut (
		.SYS_CLK(sys_clk), .RSTN(rstn), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.AVS_WAITREQUEST(avs_waitrequest), .AVS_READDATA(avs_readdata),
		.INSTR_DONE(instr_done), .TRAP_EXEC(trap_exec), .RETURN_FROM_INTERRUPT_EXEC(return_from_interrupt_exec),
		.IRQ_REQ(irq_req), .IRQ_CLR(irq_clr), .CPU_PC(cpu_pc), .CPU_X(cpu_x), .CPU_A(cpu_a),
		.CPU_CC(cpu_cc), .MEM_RDATA(mem_rdata), .MEM_ADDR(mem_addr), .MEM_RE(mem_re),
		.MEM_WE(mem_we), .MEM_WDATA(mem_wdata), .CORE_HOLD(core_hold), .PC_LOAD(pc_load),
		.PC_VALUE(pc_value), .CTX_LOAD(ctx_load), .CTX_X(ctx_x), .CTX_A(ctx_a),
		.CTX_CC(ctx_cc), .STACK_PTR_LOW(sp_low), .CUR_PRIO_HIGH_BIT(prio_hi),
		.CUR_PRIO_LOW_BIT(prio_lo)
	);
	nipc_mem_model mdl (.clk(sys_clk), .addr(mem_addr), .re(mem_re), .we(mem_we),
		.wdata(mem_wdata), .rdata(mem_rdata));

	// 125 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// run needs well under a thousand cycles, so this only fires on a hang
	initial begin
		#(8 * 20000);
		errors++;
		$display("watchdog expired");
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// one Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// one instruction end as the core signals it
	task automatic boundary(input logic return_from_interrupt, input logic trap);
		@(posedge sys_clk);
		instr_done <= 1'b1;
		return_from_interrupt_exec <= return_from_interrupt;
		trap_exec <= trap;
		@(posedge sys_clk);
		instr_done <= 1'b0;
		return_from_interrupt_exec <= 1'b0;
		trap_exec <= 1'b0;
	endtask

	task automatic irq(input logic [13:0] m, input logic clr);
		@(posedge sys_clk);
		if (clr) irq_clr <= m;
		else irq_req <= m;
		@(posedge sys_clk);
		irq_req <= '0;
		irq_clr <= '0;
	endtask

	// counts memory strobes until the program counter load shows
	task automatic wait_load(output int re, output int we, output logic ctx);
		int n;
		n = 0;
		re = 0;
		we = 0;
		do begin
			@(posedge sys_clk);
			n++;
			re += int'(mem_re === 1'b1);
			we += int'(mem_we === 1'b1);
		end while (pc_load !== 1'b1 && n < 60);
		ctx = ctx_load;
		check(32'(n < 60), 32'h1);
	endtask

	task automatic quiet(output int c);
		c = 0;
		repeat (20) begin
			@(posedge sys_clk);
			c += int'(pc_load === 1'b1 || core_hold === 1'b1);
		end
	endtask

	function automatic logic [31:0] vec(input logic [15:0] a);
		return {16'h0000, mdl.mem[a], mdl.mem[a + 16'h0001]};
	endfunction

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, avs_read, avs_write, instr_done, trap_exec, return_from_interrupt_exec} = '0;
		{avs_address, avs_writedata, irq_req, irq_clr} = '0;
		avs_byteenable = 4'hF;
		{cpu_pc, cpu_x, cpu_a, cpu_cc} = 40'h1234_11_22_E4;
		errors = 0;
		n_compared = 0;
		repeat (16) @(posedge sys_clk);
		check({prio_hi, prio_lo}, 32'h3);
		check(sp_low, 32'hFF);
		rstn <= 1'b1;
		wait_load(re_n, we_n, ctx_seen);
		check(pc_value, vec(nipc_pkg::RESET_VEC));
		check(re_n, 32'h2);
		check(we_n, 32'h0);
		bus(1'b0, nipc_pkg::REG_PRIO0, 32'h0);
		check(q[7:0], 32'hFF);
		bus(1'b1, nipc_pkg::REG_PRIO0, 32'hCF);
		bus(1'b1, nipc_pkg::REG_PRIO0, 32'h64);
		bus(1'b0, nipc_pkg::REG_PRIO0, 32'h0);
		check(q[7:0], 32'h44);
		bus(1'b0, 5'h01, 32'h0);
		check(q, 32'h0);
		// v0 l1, v1 l3, v2 l1, v3 l2, v5 l2; v0 and v4 left disabled
		bus(1'b1, nipc_pkg::REG_PRIO0, 32'h1D);
		bus(1'b1, 5'h04, 32'hF3);
		bus(1'b1, nipc_pkg::REG_ENABLE, 32'h2E);
		irq(14'h0018, 1'b0);
		boundary(1'b0, 1'b0);
		quiet(p);
		check(p, 32'h0);
		bus(1'b0, nipc_pkg::REG_PENDING, 32'h0);
		check(q, 32'h18);
		irq(14'h0010, 1'b1);
		bus(1'b0, nipc_pkg::REG_PENDING, 32'h0);
		check(q, 32'h08);
		bus(1'b1, nipc_pkg::REG_LEVEL, {30'h0, nipc_pkg::LVL_MAIN});
		irq(14'h0024, 1'b0);
		boundary(1'b0, 1'b0);
		wait_load(re_n, we_n, ctx_seen);
		check(pc_value, vec(16'hFFF4));
		check({prio_hi, prio_lo}, nipc_pkg::LVL_TWO);
		check(we_n, 32'h5);
		check(re_n, 32'h2);
		check({mdl.mem[16'h01FF], mdl.mem[16'h01FE], mdl.mem[16'h01FD], mdl.mem[16'h01FC]},
			32'h3412_1122);
		check(mdl.mem[16'h01FB], 32'hE4);
		check(sp_low, 32'hFA);
		boundary(1'b0, 1'b0);
		quiet(p);
		check(p, 32'h0);
		bus(1'b0, nipc_pkg::REG_PENDING, 32'h0);
		check(q, 32'h24);
		cpu_pc <= 16'h2345;
		cpu_cc <= 8'hC4;
		boundary(1'b0, 1'b1);
		wait_load(re_n, we_n, ctx_seen);
		check(pc_value, vec(nipc_pkg::TRAP_VEC));
		check({prio_hi, prio_lo}, 32'h3);
		check(we_n, 32'h5);
		boundary(1'b1, 1'b0);
		wait_load(re_n, we_n, ctx_seen);
		check(ctx_seen, 32'h1);
		check(pc_value, 32'h2345);
		check({ctx_x, ctx_a, ctx_cc}, 32'h1122C4);
		check(re_n, 32'h5);
		check({prio_hi, prio_lo}, nipc_pkg::LVL_TWO);
		boundary(1'b1, 1'b0);
		wait_load(re_n, we_n, ctx_seen);
		check(pc_value, 32'h1234);
		check({prio_hi, prio_lo}, nipc_pkg::LVL_MAIN);
		check(sp_low, 32'hFF);
		boundary(1'b0, 1'b0);
		wait_load(re_n, we_n, ctx_seen);
		check(pc_value, vec(16'hFFF0));
		tally_and_finish();
	end
endmodule // nested_interrupt_priority_controller_bench
`default_nettype wire

// ### verif/nipc_mem_model.sv
// behavioural program and stack memory on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module nipc_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] addr,
	input  wire logic        re,
	input  wire logic        we,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata
);
	logic [7:0] mem [0:65535];

	////////////////////////////////////////////////////////////////////////////////
	// vector table gets a byte pattern unique to each address
	initial begin
		for (int i = 16'hFFE0; i <= 16'hFFFF; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
		end
	end

	// read data one cycle after the strobe; idle cycles invert so stale bytes never pass
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= re ? mem[addr] : ~rdata;
	end
endmodule // nipc_mem_model
`default_nettype wire
